// >>> dv/cfg_requester.sv
// requester model issuing accesses and collecting read words
`timescale 1ns/1ns
module cfg_requester (
   input wire logic clk,
   input wire logic rsp_byte_valid,
   input wire logic [7:0] rsp_byte,
   input wire logic rsp_last,
   output logic req_valid = 1'b0,
   output logic req_write = 1'b0,
   output logic [7:0] req_reg = 8'h00,
   output logic [31:0] req_wdata = 32'h0,
   output logic [23:0] req_reply_id = 24'h0,
   output logic [31:0] rd_word = 32'h0,
   output logic rd_done = 1'b0
);
   task automatic access(input logic w, input logic [15:0] res, input logic [31:0] d,
      input logic [23:0] id);
      req_valid = 1'b1;
      req_write = w;
      req_reg = res[15:8];
      req_wdata = d;
      req_reply_id = id;
      @(posedge clk);
      #1 req_valid = 1'b0;
      req_reg = ~req_reg;
      req_wdata = ~d;
      req_reply_id = ~id;
      repeat (w ? 3 : 6) @(posedge clk);
      #1;
   endtask
   always @(posedge clk) begin
      rd_done <= rsp_byte_valid & rsp_last;
      if (rsp_byte_valid) rd_word <= {rd_word[23:0], rsp_byte};
   end
endmodule // cfg_requester

// >>> dv/tb.sv
// self-checking bench for the tile configuration bank
`timescale 1ns/1ns
module tb;
   logic clk = 0;
   logic nrst = 0;
   logic [31:0] boot_status_in = 0;
   logic [7:0] threads_active = 0;
   logic [7:0] threads_paused = 0;
   wire req_valid, req_write, rsp_valid, rsp_byte_valid, rsp_last, rd_done, tx_clk;
   wire eth_ports_en, lp_clk_div_active, utmi_sel, ulpi_en;
   wire [7:0] req_reg, rsp_byte, tx_delay;
   wire [23:0] req_reply_id, rsp_reply_id;
   wire [31:0] req_wdata, rd_word, brk_ctrl_flat;
   logic [31:0] q[$];
   logic [31:0] d;
   int miscompares = 0;
   int comparisons = 0;
   int seed = 32'haf880862;
   time t;
   always #4 clk = ~clk;
   tile_config_status_regs i_dut (.*);
   cfg_requester i_req (.*);
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task test_done;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk) if (rd_done === 1'b1) chk("read", rd_word, q.pop_front());
   initial begin
      #100000 miscompares++;
      test_done;
   end
   initial begin
      boot_status_in = $random(seed);
      repeat (16) @(posedge clk);
      #1 nrst = 1;
      chk("reset", {tx_delay, eth_ports_en, lp_clk_div_active, utmi_sel, ulpi_en}, 0);
      chk("reset brk", brk_ctrl_flat, 0);
      d = $random(seed);
      i_req.access(1, 16'h020b, d, 24'h1234ff);
      q.push_back(d & 32'h03ffff36);
      i_req.access(0, 16'h020b, 0, 24'h123401);
      chk("ctl", {tx_delay, eth_ports_en, utmi_sel, ulpi_en}, {d[25:18], d[8], d[2], d[1]});
      $display("control test done");
      i_req.access(1, 16'h020b, 32'h0000_0710, 24'h123402);
      chk("lp", lp_clk_div_active, 1);
      @(posedge tx_clk);
      t = $time;
      repeat (10) @(posedge tx_clk);
      chk("period", 32'($time - t), 320);
      #1 threads_active = 8'h0f;
      threads_paused = 8'h07;
      i_req.access(1, 16'h020b, 32'h0000_0030, 24'h123403);
      chk("dyn", lp_clk_div_active, 0);
      threads_paused = 8'h0f;
      repeat (5) @(posedge clk);
      #1;
      chk("dyn", lp_clk_div_active, 1);
      $display("divider test done");
      i_req.access(1, 16'h030b, ~boot_status_in, 24'h123404);
      q.push_back(boot_status_in & 32'h00ff013f);
      i_req.access(0, 16'h030b, 0, 24'h123405);
      i_req.access(0, 16'h100b, 0, 24'h123406);
      $display("boot test done");
      for (int r = 0; r < 4; r++) begin
         d = $random(seed);
         i_req.access(1, {8'h9c + r[7:0], 8'h0b}, d, 24'h000101);
         q.push_back(d & 32'h00ff0003);
         i_req.access(0, {8'h9c + r[7:0], 8'h0b}, 0, 24'h000102);
         chk("brk", brk_ctrl_flat[8*r +: 8], d[23:16]);
      end
      $display("breakpoint test done");
      repeat (2) @(posedge clk);
      chk("queue", q.size(), 0);
      test_done;
   end
endmodule // tb
bind tile_config_status_regs tile_cfg_checker i_chk (.*);

// >>> dv/tile_cfg_checker.sv
// checker for the tile configuration bank
`timescale 1ns/1ns
module tile_cfg_checker (
   input wire logic clk,
   input wire logic nrst,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [7:0] req_reg,
   input wire logic [31:0] req_wdata,
   input wire logic [23:0] req_reply_id,
   input wire logic rsp_valid,
   input wire logic [23:0] rsp_reply_id,
   input wire logic rsp_byte_valid,
   input wire logic rsp_last,
   input wire logic [7:0] tx_delay,
   input wire logic eth_ports_en,
   input wire logic lp_clk_div_active,
   input wire logic [31:0] brk_ctrl_flat
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_wr; req_valid && req_write; endsequence
   sequence s_ctl; s_wr ##0 req_reg == 8'h02; endsequence
   sequence s_bytes; rsp_byte_valid [*4] ##0 rsp_last; endsequence
   a_no_reply: assert property (s_wr ##0 req_reply_id[7:0] == 8'hff |=> !rsp_valid)
      else $error("reply not suppressed");
   a_reply_id: assert property (s_wr ##0 req_reply_id[7:0] != 8'hff |=>
      rsp_valid && rsp_reply_id == $past(req_reply_id)) else $error("bad reply id");
   a_read_frame: assert property (req_valid && !req_write && req_reg == 8'h02 |=>
      rsp_valid ##1 s_bytes) else $error("bad read frame");
   a_hdr_alone: assert property (rsp_valid |-> !rsp_byte_valid)
      else $error("header with byte");
   a_ctl_fields: assert property (s_ctl |-> ##2 {tx_delay, eth_ports_en} ==
      $past({req_wdata[25:18], req_wdata[8]}, 2)) else $error("control fields");
   a_ctl_hold: assert property ($changed(eth_ports_en) |->
      $past(req_valid && req_write && req_reg == 8'h02, 2)) else $error("enable moved");
   a_lp_static: assert property (s_ctl ##0 req_wdata[5:4] == 2'b01 |-> ##2 lp_clk_div_active)
      else $error("divider off");
   a_brk_enable: assert property (s_wr ##0 req_reg == 8'h9c |->
      ##2 brk_ctrl_flat[7:0] == $past(req_wdata[23:16], 2)) else $error("thread enables");
endmodule // tile_cfg_checker

// >>> hdl/tile_cfg_map.vh
// register map, field positions and reset values of the tile configuration bank
`ifndef TILE_CFG_MAP_VH
`define TILE_CFG_MAP_VH
`define REG_TILE_CONTROL 8'h02
`define REG_TILE_BOOT_STATUS 8'h03
`define REG_BRK_BASE 8'h9c
`define BRK_COUNT 4
`define PS_RES_TYPE 8'h0b
`define NO_REPLY_LOW 8'hff
`define CTL_DELAY_HI 25
`define CTL_DELAY_LO 18
`define CTL_DIV_HI 17
`define CTL_DIV_LO 9
`define CTL_ETH_EN 8
`define CTL_DYN 5
`define CTL_DIV_EN 4
`define CTL_UTMI 2
`define CTL_ULPI_EN 1
`define CTL_WMASK 32'h03ff_ff36
`define CTL_RESET 32'h0000_0000
`define BRK_WMASK 32'h00ff_0003
`define BRK_RESET 32'h0000_0000
`define BOOT_MASK 32'h00ff_013f
`endif

// >>> hdl/tile_config_status_regs.v
// tile configuration and status register bank
// Behaviour
// RULE1: requester sends upper 24 reply channel-end bits: node id and channel.
// RULE2: write with reply id low byte all ones gets no reply.
// RULE3: multi-byte data travels most significant byte first.
// RULE4: resource id is register number shifted left 8, ORed with 0x0b.
// RULE5: control bits 25:18 hold transmit data delay, reset zero.
// RULE6: transmit clock rises at divider field, falls at field shifted right.
// RULE7: control bit 8 enables ethernet peripheral ports, resets zero.
// RULE8: bit 5 set makes divider act only while all active threads pause.
// RULE9: control bit 4 enables low-power clock division, resets zero.
// RULE10: control bit 2 selects utmi when one, ulpi when zero.
// RULE11: control bit 1 enables ulpi hardware support.
// RULE12: boot status is read-only with processor number in bits 23:16.
// RULE13: boot status flags at bits 8,5,4,3,2 and pll mode in 1:0.
// RULE14: breakpoint bits 23:16 enable it per thread, reset zero.
// RULE15: breakpoint bit 1 picks condition a or b, resets zero.
// RULE16: breakpoint bit 0 enables the instruction breakpoint, resets zero.
// RULE17: reserved bits read zero and ignore writes.
`timescale 1ns/1ns
`include "tile_cfg_map.vh"
module tile_config_status_regs (
   input wire clk,
   input wire nrst,
   input wire req_valid,
   input wire req_write,
   input wire [7:0] req_reg,
   input wire [31:0] req_wdata,
   input wire [23:0] req_reply_id,
   input wire [31:0] boot_status_in,
   input wire [7:0] threads_active,
   input wire [7:0] threads_paused,
   output reg rsp_valid,
   output reg [23:0] rsp_reply_id,
   output reg rsp_byte_valid,
   output reg [7:0] rsp_byte,
   output reg rsp_last,
   output reg [7:0] tx_delay,
   output reg eth_ports_en,
   output reg lp_clk_div_active,
   output reg utmi_sel,
   output reg ulpi_en,
   output reg tx_clk,
   output reg [31:0] brk_ctrl_flat
);
   reg [31:0] ctl_reg;
   reg [31:0] boot_s1_reg;
   reg [31:0] boot_reg;
   reg [7:0] act_s1_reg;
   reg [7:0] act_reg;
   reg [7:0] pau_s1_reg;
   reg [7:0] pau_reg;
   reg [31:0] brk_reg [0:`BRK_COUNT-1];
   reg [31:0] rdata_next;
   reg [31:0] shift_reg;
   reg [2:0] bcount_reg;
   reg hit;
   wire tx_clk_raw;
   wire all_paused;
   wire div_run;
   integer i;
   reg [1:0] state_reg;
   wire wr_ctl;
   wire no_reply;
   wire rd_hit;
   wire req_take;
   localparam [1:0] st_idle = 2'b01;
   localparam [1:0] st_send = 2'b10;
   // two-flop capture of the boot pins
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         boot_s1_reg <= 32'h0000_0000;
         boot_reg <= 32'h0000_0000;
      end else begin
         boot_s1_reg <= boot_status_in;
         boot_reg <= boot_s1_reg & `BOOT_MASK; // RULE13
      end
   end
   // two-flop capture of the active thread mask
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         act_s1_reg <= 8'h00;
         act_reg <= 8'h00;
      end else begin
         act_s1_reg <= threads_active;
         act_reg <= act_s1_reg;
      end
   end
   // two-flop capture of the paused thread mask
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pau_s1_reg <= 8'h00;
         pau_reg <= 8'h00;
      end else begin
         pau_s1_reg <= threads_paused;
         pau_reg <= pau_s1_reg;
      end
   end
   assign all_paused = ((act_reg & ~pau_reg) == 8'h00);
   assign div_run = ctl_reg[`CTL_DIV_EN] & (~ctl_reg[`CTL_DYN] | all_paused); // RULE8 RULE9
   assign wr_ctl = req_valid & req_write & (req_reg == `REG_TILE_CONTROL);
   assign no_reply = req_write & (req_reply_id[7:0] == `NO_REPLY_LOW); // RULE2
   assign rd_hit = ~req_write & hit;
   assign req_take = req_valid & ~no_reply; // RULE2
   // read mux
   always @* begin
      rdata_next = 32'h0000_0000;
      hit = 1'b0;
      if (req_reg == `REG_TILE_CONTROL) begin
         rdata_next = ctl_reg & `CTL_WMASK; // RULE17
         hit = 1'b1;
      end else if (req_reg == `REG_TILE_BOOT_STATUS) begin
         rdata_next = boot_reg; // RULE12
         hit = 1'b1;
      end
      for (i = 0; i < `BRK_COUNT; i = i + 1) begin
         if (req_reg == (`REG_BRK_BASE + i[7:0])) begin
            rdata_next = brk_reg[i] & `BRK_WMASK;
            hit = 1'b1;
         end
      end
   end
   // control register
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         ctl_reg <= `CTL_RESET;
      else if (wr_ctl)
         ctl_reg <= req_wdata & `CTL_WMASK; // RULE5 RULE7 RULE10 RULE11 RULE17
   end
   // breakpoint registers
   genvar g;
   generate
      for (g = 0; g < `BRK_COUNT; g = g + 1) begin : brk
         wire wr_sel;
         assign wr_sel = req_valid & req_write & ({24'h00_0000, req_reg} == (`REG_BRK_BASE + g));
         always @(posedge clk or negedge nrst) begin
            if (!nrst)
               brk_reg[g] <= `BRK_RESET;
            else if (wr_sel)
               brk_reg[g] <= req_wdata & `BRK_WMASK; // RULE14 RULE15 RULE16
         end
      end
   endgenerate
   // reply: header pulse then four data bytes msb first on reads of a mapped register
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= st_idle;
         rsp_valid <= 1'b0;
         rsp_reply_id <= 24'h00_0000;
         rsp_byte_valid <= 1'b0;
         rsp_byte <= 8'h00;
         rsp_last <= 1'b0;
         shift_reg <= 32'h0000_0000;
         bcount_reg <= 3'h0;
      end else begin
         rsp_valid <= 1'b0;
         rsp_byte_valid <= 1'b0;
         rsp_last <= 1'b0;
         case (state_reg)
            st_idle: begin
               if (req_take) begin // RULE2
                  rsp_valid <= 1'b1;
                  rsp_reply_id <= req_reply_id; // RULE1
                  rsp_last <= ~rd_hit;
                  if (rd_hit) begin
                     shift_reg <= rdata_next;
                     bcount_reg <= 3'h4;
                     state_reg <= st_send;
                  end
               end
            end
            st_send: begin
               rsp_byte_valid <= 1'b1;
               rsp_byte <= shift_reg[31:24]; // RULE3
               shift_reg <= {shift_reg[23:0], 8'h00};
               rsp_last <= (bcount_reg == 3'h1);
               bcount_reg <= bcount_reg - 3'h1;
               if (bcount_reg == 3'h1)
                  state_reg <= st_idle;
            end
            default: begin
               state_reg <= st_idle;
               bcount_reg <= 3'h0;
            end
         endcase
      end
   end
   tx_clk_div u_div (
      .clk(clk),
      .nrst(nrst),
      .enable(ctl_reg[`CTL_ETH_EN]),
      .div_value(ctl_reg[`CTL_DIV_HI:`CTL_DIV_LO]),
      .tx_clk(tx_clk_raw)
   );
   // registered control outputs
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_delay <= 8'h00;
         eth_ports_en <= 1'b0;
         lp_clk_div_active <= 1'b0;
         utmi_sel <= 1'b0;
         ulpi_en <= 1'b0;
      end else begin
         tx_delay <= ctl_reg[`CTL_DELAY_HI:`CTL_DELAY_LO]; // RULE5
         eth_ports_en <= ctl_reg[`CTL_ETH_EN]; // RULE7
         lp_clk_div_active <= div_run; // RULE8
         utmi_sel <= ctl_reg[`CTL_UTMI]; // RULE10
         ulpi_en <= ctl_reg[`CTL_ULPI_EN]; // RULE11
      end
   end
   // transmit clock retimed onto the output flop
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         tx_clk <= 1'b0;
      else
         tx_clk <= tx_clk_raw;
   end
   // thread enable bytes of all breakpoints
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         brk_ctrl_flat <= 32'h0000_0000;
      else
         brk_ctrl_flat <= {brk_reg[3][23:16], brk_reg[2][23:16],
                           brk_reg[1][23:16], brk_reg[0][23:16]}; // RULE14
   end
endmodule // tile_config_status_regs

// >>> hdl/tx_clk_div.v
// transmit clock divider counting on the pll clock
`timescale 1ns/1ns
module tx_clk_div (
   input wire clk,
   input wire nrst,
   input wire enable,
   input wire [8:0] div_value,
   output reg tx_clk
);
   reg [8:0] count_reg;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_reg <= 9'h000;
         tx_clk <= 1'b0;
      end else if (!enable) begin
         count_reg <= 9'h000;
         tx_clk <= 1'b0;
      end else begin
         if (count_reg >= div_value)
            count_reg <= 9'h000;
         else
            count_reg <= count_reg + 9'h001;
         if (count_reg == div_value)
            tx_clk <= 1'b1; // RULE6
         else if (count_reg == (div_value >> 1))
            tx_clk <= 1'b0; // RULE6
      end
   end
endmodule // tx_clk_div
